// >>> arsc_pkg.sv
`default_nettype none
package arsc_pkg;
    // ==========================================================
    // Register addresses
    localparam logic [7:0] ADDR_TEMP_OFFSET_LOW = 8'h85;
    localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH = 8'h86;
    localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hd1;
    // ==========================================================
    // Field positions in reference_control
    localparam int GROUND_SELECT_BIT = 5;
    localparam int REF_SEL_HI = 4;
    localparam int REF_SEL_LO = 3;
    localparam int TEMP_ENABLE_BIT = 2;
    localparam int PREC_REF_BIT = 0;
    // Writable bit mask of reference_control
    localparam logic [7:0] REF_CTRL_WMASK = 8'h3d;
    // Reset value of reference_control
    localparam logic [7:0] REF_CTRL_RESET = 8'h18;
    // ==========================================================
    // Reference select codes
    typedef enum logic [1:0] {
        ARSC_REF_EXT_PIN = 2'b00,
        ARSC_REF_MAIN_SUPPLY = 2'b01,
        ARSC_REF_DIG_SUPPLY = 2'b10,
        ARSC_REF_HIGH_SPEED = 2'b11
    } arsc_ref_t;
endpackage
`default_nettype wire

// >>> arsc_props.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Port checker
module arsc_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [9:0] factory_offset,
    input wire logic [1:0] reference_select,
    input wire logic conv_needs_ref,
    input wire logic conv_sampling,
    input wire logic conv_converting,
    input wire logic temp_sensor_sampled,
    input wire logic analog_ground_sel,
    input wire logic temp_sensor_enable,
    input wire logic precision_ref_enable,
    input wire logic high_speed_ref_power
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_n);
a_ctrl_unused: assert property (
    sfr_rd && sfr_addr == 8'hd1 |=>
    sfr_rdata[7:6] == 2'h0 && !sfr_rdata[1]) else $error("unused bits");
a_offset_high: assert property (
    sfr_rd && sfr_addr == 8'h86 && $past(rst_n) && $stable(factory_offset)
    |=> sfr_rdata == $past(factory_offset[9:2])) else $error("offset high");
a_offset_low: assert property (
    sfr_rd && sfr_addr == 8'h85 |=>
    sfr_rdata[5:0] == 6'h0) else $error("offset low");
a_hs_on: assert property (
    conv_needs_ref && reference_select == 2'h3 ##1 $stable(reference_select)
    |-> high_speed_ref_power) else $error("hs on");
a_hs_off: assert property (
    !conv_needs_ref |=> !high_speed_ref_power) else $error("hs off");
a_temp_gnd: assert property (
    conv_sampling && temp_sensor_sampled |=>
    !analog_ground_sel) else $error("temp gnd");
a_conv_gnd: assert property (
    conv_converting && reference_select == 2'h3 ##1 $stable(reference_select)
    |-> !analog_ground_sel) else $error("conv gnd");
a_ctrl_follow: assert property (
    sfr_wr && sfr_addr == 8'hd1 |-> ##2
    reference_select == $past(sfr_wdata[4:3], 2) &&
    temp_sensor_enable == $past(sfr_wdata[2], 2)) else $error("ctrl");
a_prec_follow: assert property (
    sfr_wr && sfr_addr == 8'hd1 |-> ##2
    precision_ref_enable == $past(sfr_wdata[0], 2)) else $error("prec");
endmodule // arsc_props
bind arsc_ref_ctrl arsc_props u_props(.*);
`default_nettype wire

// >>> arsc_ref_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Unused control bits read zero, writes ignored
// - Bit 5 picks ground pin or analog ground
// - Bits 4:3 pick the voltage reference source
// - Bit 2 enables the temperature sensor
// - Bit 0 enables and connects precision reference
// - High-speed reference powered only when converter needs
// - Temp sensor sampling always uses internal ground
// - High-speed reference forces internal ground converting
// - High offset register returns offset bits 9:2
// - Low offset: bits 7:6 offset 1:0, rest zero
// - Offset holds factory value, varies per part
module arsc_ref_ctrl (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic [9:0] factory_offset,
    input wire logic conv_needs_ref,
    input wire logic conv_sampling,
    input wire logic conv_converting,
    input wire logic temp_sensor_sampled,
    output logic analog_ground_sel,
    output logic [1:0] reference_select,
    output logic temp_sensor_enable,
    output logic precision_ref_enable,
    output logic high_speed_ref_power
);
    // ==========================================================
    // Decoding helpers

    // Address match against one register of the block
    function automatic logic arsc_addr_hit(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        arsc_addr_hit = (addr == target);
    endfunction

    // Implemented bits of a control word, the rest forced to zero
    function automatic logic [7:0] arsc_ctrl_mask(input logic [7:0] word);
        arsc_ctrl_mask = word & arsc_pkg::REF_CTRL_WMASK;
    endfunction

    // Reference select field of a control word
    function automatic logic [1:0] arsc_ref_field(input logic [7:0] word);
        arsc_ref_field = word[arsc_pkg::REF_SEL_HI:arsc_pkg::REF_SEL_LO];
    endfunction

    // High-speed reference chosen by a control word
    function automatic logic arsc_is_high_speed(input logic [7:0] word);
        arsc_is_high_speed =
            (arsc_ref_field(word) == arsc_pkg::ARSC_REF_HIGH_SPEED);
    endfunction

    // Read word for the register that the address picked
    // Unmapped addresses read zero, so a stray read is harmless
    function automatic logic [7:0] arsc_read_word(
        input logic hit_ctrl,
        input logic hit_high,
        input logic hit_low,
        input logic [7:0] ctrl,
        input logic [9:0] offset
    );
        logic [7:0] word;
        word = 8'h00;
        if (hit_ctrl) begin
            word = arsc_ctrl_mask(ctrl);
        end else if (hit_high) begin
            word = offset[9:2];
        end else if (hit_low) begin
            word = {offset[1:0], 6'h00};
        end
        arsc_read_word = word;
    endfunction

    // Ground choice with the internal ground overrides
    // Overrides only apply in their own converter phase
    function automatic logic arsc_ground_pick(
        input logic ground_field,
        input logic sampling_temp,
        input logic converting_hs
    );
        logic pick;
        pick = ground_field;
        if (sampling_temp) begin
            pick = 1'h0;
        end
        if (converting_hs) begin
            pick = 1'h0;
        end
        arsc_ground_pick = pick;
    endfunction

    // ==========================================================
    // Register decode and storage

    // Address hits and the control write strobe
    logic hit_ctrl;
    logic hit_high;
    logic hit_low;
    logic ctrl_wr_en;

    // Control fields, each kept in its own register
    logic ground_sel_q;
    logic ground_sel_d;
    logic [1:0] ref_sel_q;
    logic [1:0] ref_sel_d;
    logic temp_en_q;
    logic temp_en_d;
    logic prec_en_q;
    logic prec_en_d;
    logic [7:0] ctrl_word;

    // Offset copy and converter phase qualifiers
    logic [9:0] offset_q;
    logic hs_sel;
    logic sampling_temp;
    logic converting_hs;
    logic agnd_d;

    // Address decode, shared by the write and read paths
    assign hit_ctrl =
        arsc_addr_hit(sfr_addr, arsc_pkg::ADDR_REFERENCE_CONTROL);
    assign hit_high =
        arsc_addr_hit(sfr_addr, arsc_pkg::ADDR_TEMP_OFFSET_HIGH);
    assign hit_low =
        arsc_addr_hit(sfr_addr, arsc_pkg::ADDR_TEMP_OFFSET_LOW);

    // Only the control register accepts writes
    // Offset registers have no write path at all
    assign ctrl_wr_en = sfr_wr && hit_ctrl;

    // Next field values; unused bits are never stored
    // A write replaces every implemented field at once
    always_comb begin
        ground_sel_d = ground_sel_q;
        ref_sel_d = ref_sel_q;
        temp_en_d = temp_en_q;
        prec_en_d = prec_en_q;
        if (ctrl_wr_en) begin
            ground_sel_d = sfr_wdata[arsc_pkg::GROUND_SELECT_BIT];
            ref_sel_d = arsc_ref_field(sfr_wdata);
            temp_en_d = sfr_wdata[arsc_pkg::TEMP_ENABLE_BIT];
            prec_en_d = sfr_wdata[arsc_pkg::PREC_REF_BIT];
        end
    end

    // Ground select field
    // Resets to the internal ground choice
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ground_sel_q <=
                arsc_pkg::REF_CTRL_RESET[arsc_pkg::GROUND_SELECT_BIT];
        end else begin
            ground_sel_q <= ground_sel_d;
        end
    end

    // Reference select field
    // Resets to the high-speed reference, which powers itself down
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ref_sel_q <=
                arsc_pkg::REF_CTRL_RESET[arsc_pkg::REF_SEL_HI:arsc_pkg::REF_SEL_LO];
        end else begin
            ref_sel_q <= ref_sel_d;
        end
    end

    // Temperature sensor enable field
    // Sensor stays off until software asks, saving bias current
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            temp_en_q <=
                arsc_pkg::REF_CTRL_RESET[arsc_pkg::TEMP_ENABLE_BIT];
        end else begin
            temp_en_q <= temp_en_d;
        end
    end

    // Precision reference enable field
    // Off after reset so the reference pin is free for external use
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prec_en_q <=
                arsc_pkg::REF_CTRL_RESET[arsc_pkg::PREC_REF_BIT];
        end else begin
            prec_en_q <= prec_en_d;
        end
    end

    // Control word as software sees it, unused bits zero
    assign ctrl_word = {
        2'h0,
        ground_sel_q,
        ref_sel_q,
        temp_en_q,
        1'h0,
        prec_en_q
    };

    // ==========================================================
    // Factory offset

    // Copy taken every cycle; software has no way to change it
    // The value differs from part to part, so nothing is fixed here
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            offset_q <= 10'h000;
        end else begin
            offset_q <= factory_offset;
        end
    end

    // ==========================================================
    // Read data

    // Registered read word, held until the next read strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= arsc_read_word(hit_ctrl, hit_high, hit_low,
                ctrl_word, offset_q);
        end
    end

    // ==========================================================
    // Ground overrides

    // Phase qualifiers for the two internal ground cases
    assign hs_sel = arsc_is_high_speed(ctrl_word);
    assign sampling_temp = conv_sampling && temp_sensor_sampled;
    assign converting_hs = conv_converting && hs_sel;

    // Ground choice ahead of its output register
    assign agnd_d = arsc_ground_pick(ground_sel_q, sampling_temp,
        converting_hs);

    // ==========================================================
    // Analog control outputs

    // Each control leaves through its own flop, one cycle behind
    // the register, so the analog side never sees a decode glitch
    // Ground select output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            analog_ground_sel <= 1'h0;
        end else begin
            analog_ground_sel <= agnd_d;
        end
    end

    // Reference select output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reference_select <=
                arsc_pkg::REF_CTRL_RESET[arsc_pkg::REF_SEL_HI:arsc_pkg::REF_SEL_LO];
        end else begin
            reference_select <= ref_sel_q;
        end
    end

    // Temperature sensor enable output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            temp_sensor_enable <= 1'h0;
        end else begin
            temp_sensor_enable <= temp_en_q;
        end
    end

    // Precision reference enable and pin connect output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            precision_ref_enable <= 1'h0;
        end else begin
            precision_ref_enable <= prec_en_q;
        end
    end

    // High-speed reference power, on only while the converter asks
    // No software step needed, which keeps idle current low
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            high_speed_ref_power <= 1'h0;
        end else begin
            high_speed_ref_power <= hs_sel && conv_needs_ref;
        end
    end
endmodule // arsc_ref_ctrl
`default_nettype wire

// >>> tb_arsc_ref_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module tb_arsc_ref_ctrl;
logic ref_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, g, ts_en, pe, hp;
logic nr = 0, sm = 0, cv = 0, ts = 0;
logic [7:0] a = 0, d = 0, q;
logic [9:0] fo = 10'h2b5;
logic [1:0] rs;
int mismatches = 0, num_checks = 0, cyc = 0;
always #5 ref_clk = ~ref_clk;
arsc_ref_ctrl dut(.ref_clk, .rst_n, .sfr_addr(a), .sfr_wdata(d), .sfr_wr,
    .sfr_rd, .sfr_rdata(q), .factory_offset(fo), .conv_needs_ref(nr),
    .conv_sampling(sm), .conv_converting(cv), .temp_sensor_sampled(ts),
    .analog_ground_sel(g), .reference_select(rs), .temp_sensor_enable(ts_en),
    .precision_ref_enable(pe), .high_speed_ref_power(hp));
task chk(input logic [7:0] s, e, input string n);
    num_checks++;
    if (s !== e) begin
        mismatches++;
        $display("unexpected %s exp %h seen %h", n, e, s);
    end
endtask
task wr(input logic [7:0] ad, v);
    @(negedge ref_clk) {a, d, sfr_wr} = {ad, v, 1'b1};
    @(negedge ref_clk) sfr_wr = 0;
endtask
task rd(input logic [7:0] ad, e);
    @(negedge ref_clk) {a, sfr_rd} = {ad, 1'b1};
    @(negedge ref_clk) sfr_rd = 0;
    chk(q, e, "rdata");
endtask
task stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
// Hang guard
always @(posedge ref_clk) if (++cyc > 400) begin
    mismatches++;
    stop_test;
end
initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1;
    chk({3'h0, g, rs, ts_en, pe}, 8'h0c, "reset_out");
    chk({7'h0, hp}, 8'h00, "reset_hs");
    rd(8'hd1, 8'h18);
    rd(8'hbb, 8'h00);
    $display("test reset done");
    wr(8'h85, 8'hff);
    wr(8'h86, 8'h00);
    rd(8'h86, fo[9:2]);
    rd(8'h85, {fo[1:0], 6'h0});
    $display("test offset done");
    nr = 1;
    for (int c = 0; c < 4; c++) begin
        wr(8'hd1, {3'h7, c[1:0], 3'h7});
        rd(8'hd1, {3'h1, c[1:0], 3'h5});
        chk({3'h0, g, rs, ts_en, pe}, {4'h1, c[1:0], 2'h3}, "ctrl");
        chk({7'h0, hp}, {7'h0, c == 3}, "hs");
        cv = 1;
        repeat (2) @(negedge ref_clk);
        chk({7'h0, g}, {7'h0, c != 3}, "gnd_conv");
        {cv, sm, ts} = 3'h3;
        repeat (2) @(negedge ref_clk);
        chk({7'h0, g}, 8'h0, "gnd_temp");
        {sm, ts, nr} = 3'h0;
        repeat (2) @(negedge ref_clk);
        chk({7'h0, hp}, 8'h0, "hs_off");
        nr = 1;
    end
    $display("test control done");
    wr(8'hd1, 8'h00);
    rd(8'hd1, 8'h00);
    chk({7'h0, pe}, 8'h00, "ext_ref");
    wr(8'hd1, 8'h01);
    rd(8'hd1, 8'h01);
    chk({6'h0, rs}, 8'h00, "prec_sel");
    chk({7'h0, pe}, 8'h01, "prec_on");
    $display("test software done");
    @(negedge ref_clk) rst_n = 0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1;
    chk({3'h0, g, rs, ts_en, pe}, 8'h0c, "rerst_out");
    rd(8'hd1, 8'h18);
    $display("test reset again done");
    stop_test;
end
endmodule // tb_arsc_ref_ctrl
`default_nettype wire
